//--- common/wtu_map.vh
// Register offsets, field positions, reset values and sequence words of the watchdog unit
`ifndef WTU_MAP_VH
`define WTU_MAP_VH
`define WTU_ADDR_W 16
`define WTU_RELOAD_UPPER_ADDR 16'hF4C0
`define WTU_RELOAD_LOWER_ADDR 16'hF4C2
`define WTU_COUNT_UPPER_ADDR 16'hF4C4
`define WTU_COUNT_LOWER_ADDR 16'hF4C6
`define WTU_LOCKOUT_CLEAR_ADDR 16'hF4C8
`define WTU_STATUS_ADDR 16'hF4CA
`define WTU_LOCK_WORD_FIRST 16'hF01E
`define WTU_LOCK_WORD_SECOND 16'h0FE1
`define WTU_RELOAD_RESET 16'hFFFF
`define WTU_STATUS_RESET 8'h00
`define WTU_BIT_GUARD_ON 7
`define WTU_BIT_BUS_WATCH 1
`define WTU_BIT_CLOCK_STOP 0
`endif

//--- src/wtu_watchdog.v
// Watchdog timeout unit: reload/count/status registers, lockout sequence, down-counter
//
// Functional notes
// - Inverted timeout drives slave request line seven.
// - Timeout appears on a dedicated output pin.
// - Reload halves at F4C0/F4C2, dword split.
// - Two-word lockout sequence reloads, enables guard mode.
// - Counter readable as upper and lower words.
// - Bus-watch bit writable until a lockout.
// - Guard-mode bit read-only, set by lockout.
// - Lockout clears bus-watch and clock-stop bits, blocks status writes.
// - Clock-stop bit halts the counter.
`timescale 1ns/100ps
`include "wtu_map.vh"

module wtu_watchdog (
  input wire clock,                       // 40 MHz processor clock
  input wire rst,                         // Synchronous device reset, active high
  input wire [`WTU_ADDR_W-1:0] io_addr,   // I/O address of the access
  input wire io_wr,                       // Write strobe, one cycle
  input wire io_rd,                       // Read strobe, one cycle
  input wire io_dword,                    // 1 = 32-bit write at the even address
  input wire [31:0] io_wdata,             // Write data
  output reg [15:0] io_rdata_q,           // Read data, valid cycle after io_rd
  output reg timeout_out_pin,             // Timeout, active high
  output reg slave_request_line_seven,    // Inverted timeout to interrupt controller
  output reg bus_watch_enable,            // Bus monitor mode enabled
  output reg guard_mode_on                // Watchdog mode enabled
);

  // Lockout tracker: armed by the first word, fired by the second
  localparam LK_IDLE = 1'b0;
  localparam LK_ARMED = 1'b1;
  // Reload table entries, upper half first
  localparam RL_UPPER = 1'b0;
  localparam RL_LOWER = 1'b1;

  reg [15:0] reload_q [0:1];
  reg [31:0] count_q;
  reg [31:0] count_d;
  reg timeout_q;
  reg timeout_d;
  reg lock_state_q;
  reg lock_state_d;
  reg lock_fire;
  reg guard_q;
  reg guard_d;
  reg bus_watch_q;
  reg bus_watch_d;
  reg clock_stop_q;
  reg clock_stop_d;
  reg [15:0] status_word;
  reg [15:0] rdata_d;
  wire [1:0] half_we;
  wire [31:0] half_wdata;
  wire dword_upper;
  wire wr_clear;
  wire wr_status;
  wire first_word;
  wire second_word;
  genvar gi;

  assign dword_upper = io_dword && (io_addr == `WTU_RELOAD_UPPER_ADDR);
  assign wr_clear = io_wr && (io_addr == `WTU_LOCKOUT_CLEAR_ADDR);
  assign wr_status = io_wr && (io_addr == `WTU_STATUS_ADDR);
  assign first_word = io_wdata[15:0] == `WTU_LOCK_WORD_FIRST;
  assign second_word = io_wdata[15:0] == `WTU_LOCK_WORD_SECOND;

  // A dword write at the upper address fills both halves at once
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_half
      localparam [15:0] HALF_ADDR = (gi == 0) ? `WTU_RELOAD_UPPER_ADDR :
                                    `WTU_RELOAD_LOWER_ADDR;
      assign half_we[gi] = io_wr && ((io_addr == HALF_ADDR) || dword_upper);
      assign half_wdata[gi * 16 +: 16] = dword_upper ? io_wdata[gi * 16 +: 16] :
                                         io_wdata[15:0];
    end
  endgenerate

  always @(posedge clock) begin
    if (rst) begin
      reload_q[RL_UPPER] <= `WTU_RELOAD_RESET;
      reload_q[RL_LOWER] <= `WTU_RELOAD_RESET;
    end else begin
      if (half_we[0]) begin
        reload_q[RL_UPPER] <= half_wdata[15:0];
      end
      if (half_we[1]) begin
        reload_q[RL_LOWER] <= half_wdata[31:16];
      end
    end
  end

  // Other writes may fall between the two words; a clear write of neither word disarms, a repeated first word keeps it armed
  always @* begin
    lock_state_d = lock_state_q;
    lock_fire = 1'b0;
    case (lock_state_q)
      LK_IDLE: begin
        if (wr_clear && first_word) begin
          lock_state_d = LK_ARMED;
        end
      end
      LK_ARMED: begin
        if (wr_clear && second_word) begin
          lock_fire = 1'b1;
          lock_state_d = LK_IDLE;
        end else if (wr_clear && !first_word) begin
          lock_state_d = LK_IDLE;
        end
      end
      default: begin
        lock_state_d = LK_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      lock_state_q <= LK_IDLE;
    end else begin
      lock_state_q <= lock_state_d;
    end
  end

  // Counter stalls while stopped; timeout sticks until reload
  always @* begin
    count_d = count_q;
    timeout_d = timeout_q;
    if (lock_fire) begin
      count_d = {reload_q[RL_UPPER], reload_q[RL_LOWER]};
      timeout_d = 1'b0;
    end else if (!clock_stop_q) begin
      if (count_q == 32'h0000_0000) begin
        timeout_d = 1'b1;
      end else begin
        count_d = count_q - 32'h0000_0001;
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      count_q <= {`WTU_RELOAD_RESET, `WTU_RELOAD_RESET};
      timeout_q <= 1'b0;
    end else begin
      count_q <= count_d;
      timeout_q <= timeout_d;
    end
  end

  // Lockout wins over a status write in the same cycle
  always @* begin
    guard_d = guard_q;
    bus_watch_d = bus_watch_q;
    clock_stop_d = clock_stop_q;
    if (lock_fire) begin
      guard_d = 1'b1;
      bus_watch_d = 1'b0;
      clock_stop_d = 1'b0;
    end else if (wr_status && !guard_q) begin
      bus_watch_d = io_wdata[`WTU_BIT_BUS_WATCH];
      clock_stop_d = io_wdata[`WTU_BIT_CLOCK_STOP];
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      guard_q <= 1'b0;
      bus_watch_q <= 1'b0;
      clock_stop_q <= 1'b0;
    end else begin
      guard_q <= guard_d;
      bus_watch_q <= bus_watch_d;
      clock_stop_q <= clock_stop_d;
    end
  end

  always @* begin
    status_word = {8'h00, `WTU_STATUS_RESET};
    status_word[`WTU_BIT_GUARD_ON] = guard_q;
    status_word[`WTU_BIT_BUS_WATCH] = bus_watch_q;
    status_word[`WTU_BIT_CLOCK_STOP] = clock_stop_q;
  end

  // Count halves are not latched together: the count moves between reads
  always @* begin
    case (io_addr)
      `WTU_RELOAD_UPPER_ADDR: begin
        rdata_d = reload_q[RL_UPPER];
      end
      `WTU_RELOAD_LOWER_ADDR: begin
        rdata_d = reload_q[RL_LOWER];
      end
      `WTU_COUNT_UPPER_ADDR: begin
        rdata_d = count_q[31:16];
      end
      `WTU_COUNT_LOWER_ADDR: begin
        rdata_d = count_q[15:0];
      end
      `WTU_STATUS_ADDR: begin
        rdata_d = status_word;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      io_rdata_q <= 16'h0000;
    end else if (io_rd) begin
      io_rdata_q <= rdata_d;
    end
  end

  // Pin-side copies, each registered from the same next-state value as its flop
  always @(posedge clock) begin
    if (rst) begin
      timeout_out_pin <= 1'b0;
      slave_request_line_seven <= 1'b1;
      bus_watch_enable <= 1'b0;
      guard_mode_on <= 1'b0;
    end else begin
      timeout_out_pin <= timeout_d;
      slave_request_line_seven <= ~timeout_d;
      bus_watch_enable <= bus_watch_d;
      guard_mode_on <= guard_d;
    end
  end

endmodule // wtu_watchdog

//--- tb/wtu_irq_model.sv
// Edge-triggered request catcher in place of the interrupt controller
`timescale 1ns/100ps
module wtu_irq_model (
  input wire clock, // clock
  input wire rst, // reset
  input wire req_n, // request, active low
  output reg [3:0] hits_q // requests taken
);
  reg last_q;
  always @(posedge clock) begin
    last_q <= req_n;
    if (rst) hits_q <= 4'h0;
    else if (last_q && !req_n) hits_q <= hits_q + 4'h1; // Edge only, a level floods
  end
endmodule // wtu_irq_model

//--- tb/wtu_watchdog_assertions.sv
// Port checks of the watchdog unit
`timescale 1ns/100ps
module wtu_chk (
  input wire clock, // clk
  input wire rst, // rst
  input wire [15:0] io_addr, // in
  input wire io_wr, // in
  input wire io_rd, // in
  input wire [31:0] io_wdata, // in
  input wire [15:0] io_rdata_q, // out
  input wire timeout_out_pin, // out
  input wire slave_request_line_seven, // out
  input wire bus_watch_enable, // out
  input wire guard_mode_on // out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire clr = io_wr && io_addr == 16'hF4C8;
  line_inverse_a: assert property (slave_request_line_seven == !timeout_out_pin)
    else $error("line seven not inverse");
  lockout_effect_a: assert property (clr && io_wdata[15:0] == 16'hF01E ##1
    clr && io_wdata[15:0] == 16'h0FE1 |=> guard_mode_on && !timeout_out_pin)
    else $error("lockout missed");
  guard_sticky_a: assert property (guard_mode_on |=> guard_mode_on) else $error("guard fell");
  guard_source_a: assert property ($rose(guard_mode_on) |-> $past(clr))
    else $error("guard set without lockout");
  watch_locked_a: assert property (guard_mode_on |-> !bus_watch_enable)
    else $error("bus watch on after lockout");
  watch_write_a: assert property (!guard_mode_on && io_wr && io_addr == 16'hF4CA
    |=> bus_watch_enable == $past(io_wdata[1])) else $error("bus watch write lost");
  timeout_hold_a: assert property (timeout_out_pin && !clr |=> timeout_out_pin)
    else $error("timeout dropped");
  rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata_q)) else $error("rdata moved");
endmodule // wtu_chk
bind wtu_watchdog wtu_chk u_chk (.*);

//--- tb/tb.sv
// Self-checking bench for the watchdog timeout unit
`timescale 1ns/100ps
module tb;
  reg clock = 0, rst = 1, io_wr = 0, io_rd = 0, io_dword = 0;
  reg [15:0] io_addr = 16'h0000, v, s;
  reg [31:0] io_wdata = 32'h0;
  wire [15:0] io_rdata_q;
  wire timeout_out_pin, slave_request_line_seven, bus_watch_enable, guard_mode_on;
  wire [3:0] hits_q;
  integer bad_count = 0, comparisons = 0;
  always #12.5 clock = ~clock;
  wtu_watchdog u_dut (.clock, .rst, .io_addr, .io_wr, .io_rd, .io_dword, .io_wdata, .io_rdata_q,
    .timeout_out_pin, .slave_request_line_seven, .bus_watch_enable, .guard_mode_on);
  wtu_irq_model u_irq (.clock, .rst, .req_n(slave_request_line_seven), .hits_q);
  task chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task op(input [15:0] a, input [31:0] d, input w, input dw);
    @(posedge clock) #1;
    {io_addr, io_wdata, io_wr, io_rd, io_dword} = {a, d, w, !w, dw};
    @(posedge clock) #1;
    {io_wr, io_rd} = 2'b00;
    v = io_rdata_q;
  endtask
  task t_reload;
    op(16'hF4C0, 32'hCCCC4321, 1, 1);
    op(16'hF4C0, 0, 0, 0); chk("upper", 16'h4321, v);
    op(16'hF4C2, 0, 0, 0); chk("lower", 16'hCCCC, v);
    $display("reload test done");
  endtask
  task t_status;
    op(16'hF4CA, 2, 1, 0); chk("watch on", 1, bus_watch_enable);
    op(16'hF4CA, 1, 1, 0); chk("watch off", 0, bus_watch_enable);
    op(16'hF4C6, 0, 0, 0); s = v;
    op(16'hF4C6, 0, 0, 0); chk("stopped", s, v);
    op(16'hF4C4, 0, 0, 0); chk("count high", 16'hFFFF, v);
    op(16'hF4CA, 0, 0, 0); chk("status", 16'h0001, v);
    $display("status test done");
  endtask
  task t_lock;
    op(16'hF4C0, 32'h00080000, 1, 1); // Reload of eight, upper half zero
    op(16'hF4C8, 16'hF01E, 1, 0);
    op(16'hF4C8, 16'h0FE1, 1, 0); chk("guard", 1, guard_mode_on);
    op(16'hF4CA, 2, 1, 0); chk("locked", 0, bus_watch_enable);
    op(16'hF4CA, 0, 0, 0); chk("status locked", 16'h0080, v);
    repeat (20) @(posedge clock);
    #1;
    chk("timeout", 1, timeout_out_pin);
    chk("irq", 1, hits_q);
    op(16'hF4C4, 0, 0, 0); chk("count", 0, v);
    $display("lockout test done");
  endtask
  task t_relock;
    @(posedge clock) #1;
    {io_addr, io_wdata, io_wr, io_rd, io_dword} = {16'hF4C8, 32'h0000F01E, 3'b100};
    @(posedge clock) #1;
    io_wdata = 32'h00000FE1; // Back to back, strobe held high
    @(posedge clock) #1;
    io_wr = 0;
    chk("relock clears timeout", 0, timeout_out_pin);
    chk("guard kept", 1, guard_mode_on);
    repeat (20) @(posedge clock);
    #1;
    chk("timeout again", 1, timeout_out_pin);
    chk("second irq", 2, hits_q);
    $display("relock test done");
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #5000 bad_count++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 0;
    t_reload;
    t_status;
    t_lock;
    t_relock;
    close_out;
  end
endmodule // tb
